// *** common/demand_mode_pkg.sv ***
// shared constants and types of the demand-to-drive mode controller
package demand_mode_pkg;
  localparam int DEMAND_W = 10;
  localparam int DUTY_W = 10;
  localparam int SPEED_W = 16;
  localparam int THR_W = 10;
  localparam int CUR_MSB_W = 5;
  localparam int SR_W = 3;
  localparam int GAIN_W = 4;
  localparam int LIMIT_W = 5;
  localparam int DF_W = 2;
  localparam int ACC_W = 20;
  localparam logic [DEMAND_W-1:0] DEMAND_ZERO = 10'h000;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h3ff;
  localparam logic [SR_W-1:0] SR_CODE_MAX = 3'h5;
  localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
  localparam int DUTY_FRAC = 10;
  typedef enum logic [2:0] {
    MODE_OPEN = 3'h1,
    MODE_CURRENT = 3'h2,
    MODE_SPEED = 3'h4
  } ctrl_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_RUN = 4'h4,
    ST_LOST = 4'h8
  } drive_state_t;
endpackage

// *** src/speed_reference.sv ***
// reference speed in 0.1 Hz electrical units from demand and resolution code
module speed_reference (
  input wire logic [demand_mode_pkg::DEMAND_W-1:0] demand,
  input wire logic [demand_mode_pkg::SR_W-1:0] res_sel,
  output logic [demand_mode_pkg::SPEED_W-1:0] ref_speed
);
  logic [demand_mode_pkg::SR_W-1:0] code;
  // codes above five saturate at the coarsest resolution
  always_comb begin
    code = (res_sel > demand_mode_pkg::SR_CODE_MAX) ? demand_mode_pkg::SR_CODE_MAX : res_sel;
    ref_speed = demand_mode_pkg::SPEED_W'({6'h00, demand} << code);
  end
endmodule

// *** src/speed_error_gain.sv ***
// clamped speed error times gain gives the duty step
module speed_error_gain (
  input wire logic [demand_mode_pkg::SPEED_W-1:0] ref_speed,
  input wire logic [demand_mode_pkg::SPEED_W-1:0] motor_speed,
  input wire logic [demand_mode_pkg::GAIN_W-1:0] gain,
  input wire logic [demand_mode_pkg::LIMIT_W-1:0] err_limit,
  input wire logic [demand_mode_pkg::DF_W-1:0] decel_div,
  output logic signed [demand_mode_pkg::ACC_W:0] step
);
  logic signed [demand_mode_pkg::SPEED_W:0] err;
  logic signed [demand_mode_pkg::SPEED_W:0] acc_lim;
  logic signed [demand_mode_pkg::SPEED_W:0] dec_lim;
  logic [demand_mode_pkg::DF_W:0] div;
  always_comb begin
    err = $signed({1'b0, ref_speed}) - $signed({1'b0, motor_speed});
    acc_lim = $signed({12'h000, err_limit});
    div = (decel_div == 2'h0) ? 3'h1 : {1'b0, decel_div};
    dec_lim = acc_lim / $signed({14'h0000, div});
    if (err > acc_lim) begin
      err = acc_lim;
    end else if (err < -dec_lim) begin
      err = -dec_lim;
    end
    step = (demand_mode_pkg::ACC_W+1)'(err * $signed({1'b0, gain}));
  end
endmodule

// *** src/bldc_demand_mode_controller.sv ***
// demand-to-drive mode controller: duty, current threshold, speed loop, sync loss
module bldc_demand_mode_controller (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [2:0] CTRL_MODE,
  input wire logic RUN_ENABLE,
  input wire logic RESTART_ON_SYNC_LOSS_ENABLE,
  input wire logic CURRENT_LIMIT_ENABLE,
  input wire logic [demand_mode_pkg::DEMAND_W-1:0] DEMAND_INPUT,
  input wire logic [demand_mode_pkg::THR_W-1:0] CURRENT_THRESHOLD_MAX,
  input wire logic [demand_mode_pkg::SR_W-1:0] SPEED_RESOLUTION_SELECT,
  input wire logic [demand_mode_pkg::SPEED_W-1:0] START_RAMP_END_SPEED,
  input wire logic [demand_mode_pkg::SPEED_W-1:0] UNDERSPEED_FREQUENCY,
  input wire logic [demand_mode_pkg::GAIN_W-1:0] SPEED_GAIN,
  input wire logic [demand_mode_pkg::LIMIT_W-1:0] SPEED_ERROR_LIMIT,
  input wire logic [demand_mode_pkg::DF_W-1:0] DECEL_FACTOR,
  input wire logic [demand_mode_pkg::SPEED_W-1:0] MOTOR_SPEED,
  input wire logic MOTOR_SYNCED,
  input wire logic PWM_PERIOD_START,
  input wire logic STATUS_READ_CLEAR,
  output logic [demand_mode_pkg::DUTY_W-1:0] PEAK_DUTY,
  output logic [demand_mode_pkg::THR_W-1:0] CURRENT_THRESHOLD,
  output logic CURRENT_LIMIT_ACTIVE,
  output logic BRIDGE_ENABLE,
  output logic START_SEQ_RESET,
  output logic START_SEQ_GO,
  output logic DESYNC_FLAG,
  output logic [demand_mode_pkg::SPEED_W-1:0] REFERENCE_SPEED
);
  demand_mode_pkg::drive_state_t state_reg, state_next;
  logic [demand_mode_pkg::DEMAND_W-1:0] demand_reg, demand_next;
  logic [2:0] mode_reg, mode_next;
  logic [demand_mode_pkg::ACC_W-1:0] acc_reg, acc_next;
  logic [demand_mode_pkg::DUTY_W-1:0] duty_reg, duty_next;
  logic [demand_mode_pkg::THR_W-1:0] thr_reg, thr_next;
  logic bridge_reg, bridge_next;
  logic seq_rst_reg, seq_rst_next;
  logic go_reg, go_next;
  logic desync_reg, desync_next;
  logic [demand_mode_pkg::SPEED_W-1:0] ref_speed;
  logic signed [demand_mode_pkg::ACC_W:0] step;
  logic signed [demand_mode_pkg::ACC_W+1:0] acc_sum;
  logic demand_zero, underspeed, is_speed, above_ramp, may_start;

  speed_reference u_ref (
    .demand(demand_reg),
    .res_sel(SPEED_RESOLUTION_SELECT),
    .ref_speed(ref_speed)
  );

  speed_error_gain u_gain (
    .ref_speed(ref_speed),
    .motor_speed(MOTOR_SPEED),
    .gain(SPEED_GAIN),
    .err_limit(SPEED_ERROR_LIMIT),
    .decel_div(DECEL_FACTOR),
    .step(step)
  );

  always_comb begin
    demand_zero = (demand_reg == demand_mode_pkg::DEMAND_ZERO);
    is_speed = (mode_reg == demand_mode_pkg::MODE_SPEED);
    above_ramp = (ref_speed > START_RAMP_END_SPEED);
    // speed mode waits for the reference to pass the ramp end speed
    may_start = !demand_zero && (!is_speed || above_ramp);
    underspeed = MOTOR_SYNCED && (MOTOR_SPEED < UNDERSPEED_FREQUENCY);
    acc_sum = $signed({2'b00, acc_reg}) + step;
  end

  always_comb begin
    state_next = state_reg;
    demand_next = demand_reg;
    mode_next = mode_reg;
    acc_next = acc_reg;
    duty_next = duty_reg;
    thr_next = thr_reg;
    bridge_next = bridge_reg;
    seq_rst_next = 1'b0;
    go_next = 1'b0;
    // a status read clears the flag; a loss set later in this process wins
    desync_next = desync_reg && !STATUS_READ_CLEAR;
    if (PWM_PERIOD_START) begin
      demand_next = DEMAND_INPUT;
      mode_next = CTRL_MODE;
    end
    case (state_reg)
      demand_mode_pkg::ST_IDLE: begin
        bridge_next = 1'b0;
        if (RUN_ENABLE && may_start) begin
          state_next = demand_mode_pkg::ST_START;
          go_next = 1'b1;
          bridge_next = 1'b1;
        end
      end
      demand_mode_pkg::ST_START, demand_mode_pkg::ST_RUN: begin
        bridge_next = 1'b1;
        if (MOTOR_SYNCED) begin
          state_next = demand_mode_pkg::ST_RUN;
        end
        if (demand_zero || (is_speed && !above_ramp && !MOTOR_SYNCED)) begin
          state_next = demand_mode_pkg::ST_IDLE;
          bridge_next = 1'b0;
        end else if (underspeed) begin
          desync_next = 1'b1;
          seq_rst_next = 1'b1;
          if (RESTART_ON_SYNC_LOSS_ENABLE && may_start) begin
            state_next = demand_mode_pkg::ST_START;
            go_next = 1'b1;
          end else begin
            state_next = demand_mode_pkg::ST_LOST;
            bridge_next = !is_speed;
          end
        end
      end
      demand_mode_pkg::ST_LOST: begin
        bridge_next = !is_speed;
        // serial status read releases the hold only outside speed mode
        if (demand_zero || (STATUS_READ_CLEAR && !is_speed)) begin
          state_next = demand_mode_pkg::ST_IDLE;
          bridge_next = 1'b0;
        end else if (RESTART_ON_SYNC_LOSS_ENABLE && may_start) begin
          state_next = demand_mode_pkg::ST_START;
          seq_rst_next = 1'b1;
          go_next = 1'b1;
          bridge_next = 1'b1;
        end
      end
      default: begin
        state_next = demand_mode_pkg::ST_IDLE;
        bridge_next = 1'b0;
      end
    endcase
    if (PWM_PERIOD_START) begin
      case (mode_reg)
        demand_mode_pkg::MODE_OPEN: begin
          duty_next = demand_reg;
          thr_next = CURRENT_THRESHOLD_MAX;
        end
        demand_mode_pkg::MODE_CURRENT: begin
          duty_next = demand_mode_pkg::DUTY_MAX;
          thr_next = demand_mode_pkg::THR_W'(({5'h00, demand_reg[9:5]} *
                     {5'h00, CURRENT_THRESHOLD_MAX}) >> demand_mode_pkg::CUR_MSB_W);
        end
        demand_mode_pkg::MODE_SPEED: begin
          thr_next = CURRENT_THRESHOLD_MAX;
          if (state_reg == demand_mode_pkg::ST_RUN) begin
            if (acc_sum < 0) begin
              acc_next = demand_mode_pkg::ACC_RESET;
            end else if (acc_sum > $signed({2'b00, demand_mode_pkg::DUTY_MAX, 10'h000})) begin
              acc_next = {demand_mode_pkg::DUTY_MAX, 10'h000};
            end else begin
              acc_next = acc_sum[demand_mode_pkg::ACC_W-1:0];
            end
          end else if (state_reg != demand_mode_pkg::ST_START) begin
            acc_next = demand_mode_pkg::ACC_RESET;
          end
          duty_next = acc_next[demand_mode_pkg::ACC_W-1 -: demand_mode_pkg::DUTY_W];
        end
        default: begin
          duty_next = duty_reg;
        end
      endcase
    end
    if (!RUN_ENABLE) begin
      state_next = demand_mode_pkg::ST_IDLE;
      bridge_next = 1'b0;
      go_next = 1'b0;
      acc_next = demand_mode_pkg::ACC_RESET;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg <= demand_mode_pkg::ST_IDLE;
      demand_reg <= demand_mode_pkg::DEMAND_ZERO;
      mode_reg <= demand_mode_pkg::MODE_OPEN;
      acc_reg <= demand_mode_pkg::ACC_RESET;
      duty_reg <= '0;
      thr_reg <= '0;
      bridge_reg <= 1'b0;
      seq_rst_reg <= 1'b0;
      go_reg <= 1'b0;
      desync_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      demand_reg <= demand_next;
      mode_reg <= mode_next;
      acc_reg <= acc_next;
      duty_reg <= duty_next;
      thr_reg <= thr_next;
      bridge_reg <= bridge_next;
      seq_rst_reg <= seq_rst_next;
      go_reg <= go_next;
      desync_reg <= desync_next;
    end
  end

  always_comb begin
    PEAK_DUTY = duty_reg;
    CURRENT_THRESHOLD = thr_reg;
    CURRENT_LIMIT_ACTIVE = CURRENT_LIMIT_ENABLE && bridge_reg;
    BRIDGE_ENABLE = bridge_reg && RUN_ENABLE;
    START_SEQ_RESET = seq_rst_reg;
    START_SEQ_GO = go_reg;
    DESYNC_FLAG = desync_reg;
    REFERENCE_SPEED = ref_speed;
  end
endmodule

// *** tb/demand_mode_monitor.sv ***
// port-level checker of the demand mode controller
module demand_mode_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [2:0] CTRL_MODE,
  input wire logic RUN_ENABLE,
  input wire logic RESTART_ON_SYNC_LOSS_ENABLE,
  input wire logic CURRENT_LIMIT_ENABLE,
  input wire logic [9:0] DEMAND_INPUT,
  input wire logic [2:0] SPEED_RESOLUTION_SELECT,
  input wire logic [15:0] UNDERSPEED_FREQUENCY,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic MOTOR_SYNCED,
  input wire logic PWM_PERIOD_START,
  input wire logic [9:0] PEAK_DUTY,
  input wire logic [9:0] CURRENT_THRESHOLD,
  input wire logic CURRENT_LIMIT_ACTIVE,
  input wire logic BRIDGE_ENABLE,
  input wire logic START_SEQ_RESET,
  input wire logic START_SEQ_GO,
  input wire logic DESYNC_FLAG,
  input wire logic [15:0] REFERENCE_SPEED
);
  logic under;
  assign under = MOTOR_SPEED < UNDERSPEED_FREQUENCY;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_run_low_off: assert property (!RUN_ENABLE |-> !BRIDGE_ENABLE)
    else $error("bridge on while run low");
  a_go_needs_run: assert property (START_SEQ_GO |-> $past(RUN_ENABLE))
    else $error("start launched without run");
  a_limit_follows: assert property (RUN_ENABLE |->
    CURRENT_LIMIT_ACTIVE == (CURRENT_LIMIT_ENABLE && BRIDGE_ENABLE))
    else $error("current limit state wrong");
  a_duty_at_period: assert property ($changed(PEAK_DUTY) |-> $past(PWM_PERIOD_START))
    else $error("duty moved off period");
  a_thr_at_period: assert property ($changed(CURRENT_THRESHOLD) |-> $past(PWM_PERIOD_START))
    else $error("threshold moved off period");
  a_ref_at_period: assert property ($changed(REFERENCE_SPEED) && $stable(SPEED_RESOLUTION_SELECT)
    |-> $past(PWM_PERIOD_START))
    else $error("reference moved off period");
  a_loss_cause: assert property ($rose(DESYNC_FLAG) |-> $past(MOTOR_SYNCED) && $past(under))
    else $error("sync loss without underspeed");
  a_loss_seq_reset: assert property ($rose(DESYNC_FLAG) |-> START_SEQ_RESET)
    else $error("no sequencer reset on loss");
  a_restart_go: assert property ($rose(DESYNC_FLAG) && $past(RESTART_ON_SYNC_LOSS_ENABLE)
    && $past(RUN_ENABLE)
    && CTRL_MODE == demand_mode_pkg::MODE_OPEN && DEMAND_INPUT != 10'h000 |-> START_SEQ_GO)
    else $error("no restart after loss");
  c_go: cover property (START_SEQ_GO);
  c_loss: cover property ($rose(DESYNC_FLAG));
  c_duty: cover property ($changed(PEAK_DUTY));
endmodule
bind bldc_demand_mode_controller demand_mode_monitor u_mon (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .CTRL_MODE(CTRL_MODE),
  .RUN_ENABLE(RUN_ENABLE),
  .RESTART_ON_SYNC_LOSS_ENABLE(RESTART_ON_SYNC_LOSS_ENABLE),
  .CURRENT_LIMIT_ENABLE(CURRENT_LIMIT_ENABLE),
  .DEMAND_INPUT(DEMAND_INPUT),
  .SPEED_RESOLUTION_SELECT(SPEED_RESOLUTION_SELECT),
  .UNDERSPEED_FREQUENCY(UNDERSPEED_FREQUENCY),
  .MOTOR_SPEED(MOTOR_SPEED),
  .MOTOR_SYNCED(MOTOR_SYNCED),
  .PWM_PERIOD_START(PWM_PERIOD_START),
  .PEAK_DUTY(PEAK_DUTY),
  .CURRENT_THRESHOLD(CURRENT_THRESHOLD),
  .CURRENT_LIMIT_ACTIVE(CURRENT_LIMIT_ACTIVE),
  .BRIDGE_ENABLE(BRIDGE_ENABLE),
  .START_SEQ_RESET(START_SEQ_RESET),
  .START_SEQ_GO(START_SEQ_GO),
  .DESYNC_FLAG(DESYNC_FLAG),
  .REFERENCE_SPEED(REFERENCE_SPEED)
);

// *** tb/motor_model.sv ***
// bridge and motor stand-in: syncs after a start, reports electrical speed
module motor_model (
  input wire logic clk,
  input wire logic bridge_en,
  input wire logic go,
  input wire logic seq_rst,
  input wire logic [15:0] speed_cmd,
  output logic synced,
  output logic [15:0] speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // speed is electrical cycle rate in 0.1 Hz units
  assign speed = speed_cmd;
  always @(posedge clk) begin
    synced <= go ? 1'b1 : (seq_rst || !bridge_en) ? 1'b0 : synced;
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench of the demand mode controller
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
`define WAITFOR(c) begin k = 0; while (!(c) && k < 50) begin tick(1); k++; end \
  if (!(c)) begin error_cnt++; close_out(); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET_N, RUN_ENABLE, RESTART_ON_SYNC_LOSS_ENABLE, CURRENT_LIMIT_ENABLE;
  logic MOTOR_SYNCED, PWM_PERIOD_START, STATUS_READ_CLEAR, CURRENT_LIMIT_ACTIVE, BRIDGE_ENABLE;
  logic START_SEQ_RESET, START_SEQ_GO, DESYNC_FLAG;
  logic [2:0] CTRL_MODE, SPEED_RESOLUTION_SELECT;
  logic [3:0] SPEED_GAIN;
  logic [4:0] SPEED_ERROR_LIMIT;
  logic [1:0] DECEL_FACTOR;
  logic [9:0] DEMAND_INPUT, CURRENT_THRESHOLD_MAX, PEAK_DUTY, CURRENT_THRESHOLD;
  logic [15:0] START_RAMP_END_SPEED, UNDERSPEED_FREQUENCY, MOTOR_SPEED, REFERENCE_SPEED, speed_cmd;
  int error_cnt = 0;
  int n_tests = 0;
  int k;
  bldc_demand_mode_controller DUT (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .CTRL_MODE(CTRL_MODE),
    .RUN_ENABLE(RUN_ENABLE),
    .RESTART_ON_SYNC_LOSS_ENABLE(RESTART_ON_SYNC_LOSS_ENABLE),
    .CURRENT_LIMIT_ENABLE(CURRENT_LIMIT_ENABLE),
    .DEMAND_INPUT(DEMAND_INPUT),
    .CURRENT_THRESHOLD_MAX(CURRENT_THRESHOLD_MAX),
    .SPEED_RESOLUTION_SELECT(SPEED_RESOLUTION_SELECT),
    .START_RAMP_END_SPEED(START_RAMP_END_SPEED),
    .UNDERSPEED_FREQUENCY(UNDERSPEED_FREQUENCY),
    .SPEED_GAIN(SPEED_GAIN),
    .SPEED_ERROR_LIMIT(SPEED_ERROR_LIMIT),
    .DECEL_FACTOR(DECEL_FACTOR),
    .MOTOR_SPEED(MOTOR_SPEED),
    .MOTOR_SYNCED(MOTOR_SYNCED),
    .PWM_PERIOD_START(PWM_PERIOD_START),
    .STATUS_READ_CLEAR(STATUS_READ_CLEAR),
    .PEAK_DUTY(PEAK_DUTY),
    .CURRENT_THRESHOLD(CURRENT_THRESHOLD),
    .CURRENT_LIMIT_ACTIVE(CURRENT_LIMIT_ACTIVE),
    .BRIDGE_ENABLE(BRIDGE_ENABLE),
    .START_SEQ_RESET(START_SEQ_RESET),
    .START_SEQ_GO(START_SEQ_GO),
    .DESYNC_FLAG(DESYNC_FLAG),
    .REFERENCE_SPEED(REFERENCE_SPEED)
  );
  motor_model partner (.clk(CLK), .bridge_en(BRIDGE_ENABLE), .go(START_SEQ_GO),
    .seq_rst(START_SEQ_RESET), .speed_cmd(speed_cmd), .synced(MOTOR_SYNCED), .speed(MOTOR_SPEED));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pulse();
    PWM_PERIOD_START = 1'b1;
    tick(1);
    PWM_PERIOD_START = 1'b0;
  endtask
  // two periods: capture the demand, then apply it
  task automatic apply(input logic [2:0] m, input logic [9:0] d);
    CTRL_MODE = m;
    DEMAND_INPUT = d;
    repeat (2) begin
      pulse();
      tick(2);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {RESET_N, RUN_ENABLE, RESTART_ON_SYNC_LOSS_ENABLE, PWM_PERIOD_START, STATUS_READ_CLEAR} = 5'h00;
    CURRENT_LIMIT_ENABLE = 1'b1;
    CTRL_MODE = demand_mode_pkg::MODE_OPEN;
    {SPEED_RESOLUTION_SELECT, SPEED_GAIN, SPEED_ERROR_LIMIT, DECEL_FACTOR} = 14'h0000;
    {DEMAND_INPUT, CURRENT_THRESHOLD_MAX} = 20'h003ff;
    {START_RAMP_END_SPEED, UNDERSPEED_FREQUENCY, speed_cmd} = 48'h1000_0100_7000;
    repeat (8) @(posedge CLK);
    #1;
    RESET_N = 1'b1;
    `CHK("flag", 1'b0, DESYNC_FLAG)
    apply(demand_mode_pkg::MODE_OPEN, 10'h3ff);
    `CHK("duty max", 10'h3ff, PEAK_DUTY)
    `CHK("bridge off", 1'b0, BRIDGE_ENABLE)
    apply(demand_mode_pkg::MODE_OPEN, 10'h001);
    `CHK("duty min", 10'h001, PEAK_DUTY)
    apply(demand_mode_pkg::MODE_CURRENT, 10'h3e0);
    `CHK("thr top", 10'h3df, CURRENT_THRESHOLD)
    apply(demand_mode_pkg::MODE_CURRENT, 10'h01f);
    `CHK("thr low bits", 10'h000, CURRENT_THRESHOLD)
    for (int c = 0; c < 6; c++) begin
      SPEED_RESOLUTION_SELECT = 3'(c);
      apply(demand_mode_pkg::MODE_SPEED, 10'h3ff);
      `CHK("reference", 16'h03ff << c, REFERENCE_SPEED)
    end
    RUN_ENABLE = 1'b1;
    SPEED_RESOLUTION_SELECT = 3'h0;
    apply(demand_mode_pkg::MODE_SPEED, 10'h010);
    `CHK("coast", 1'b0, BRIDGE_ENABLE)
    RUN_ENABLE = 1'b0;
    SPEED_RESOLUTION_SELECT = 3'h5;
    // gain 15, error limit 31, deceleration factor 3
    {SPEED_GAIN, SPEED_ERROR_LIMIT, DECEL_FACTOR} = 11'h7ff;
    apply(demand_mode_pkg::MODE_SPEED, 10'h3ff);
    RUN_ENABLE = 1'b1;
    `WAITFOR(START_SEQ_GO)
    tick(3);
    repeat (5) begin
      pulse();
      tick(1);
    end
    `CHK("accelerate", 10'((5 * 31 * 15) >> 10), PEAK_DUTY)
    speed_cmd = 16'h7ff0;
    repeat (2) begin
      pulse();
      tick(1);
    end
    `CHK("decelerate", 10'((5 * 31 * 15 - 2 * (31 / 3) * 15) >> 10), PEAK_DUTY)
    speed_cmd = 16'h0010;
    `WAITFOR(DESYNC_FLAG)
    tick(2);
    `CHK("speed loss off", 1'b0, BRIDGE_ENABLE)
    RUN_ENABLE = 1'b0;
    speed_cmd = 16'h7000;
    STATUS_READ_CLEAR = 1'b1;
    tick(1);
    STATUS_READ_CLEAR = 1'b0;
    apply(demand_mode_pkg::MODE_OPEN, 10'h200);
    `CHK("flag read clear", 1'b0, DESYNC_FLAG)
    RESTART_ON_SYNC_LOSS_ENABLE = 1'b1;
    RUN_ENABLE = 1'b1;
    `WAITFOR(START_SEQ_GO)
    tick(3);
    speed_cmd = 16'h0010;
    `WAITFOR(DESYNC_FLAG)
    `CHK("restart", 1'b1, START_SEQ_GO)
    `CHK("sequencer reset", 1'b1, START_SEQ_RESET)
    speed_cmd = 16'h7000;
    RESTART_ON_SYNC_LOSS_ENABLE = 1'b0;
    tick(4);
    STATUS_READ_CLEAR = 1'b1;
    tick(1);
    STATUS_READ_CLEAR = 1'b0;
    tick(1);
    `CHK("flag cleared", 1'b0, DESYNC_FLAG)
    `CHK("bridge on", 1'b1, BRIDGE_ENABLE)
    `CHK("limit on", 1'b1, CURRENT_LIMIT_ACTIVE)
    RUN_ENABLE = 1'b0;
    #1;
    `CHK("run low", 1'b0, BRIDGE_ENABLE)
    close_out();
  end
endmodule
